// File: src/ppsc_consts.svh
`ifndef PPSC_CONSTS_SVH
`define PPSC_CONSTS_SVH

// sleep-state field encodings carried in a stop-clock packet
`define PPSC_SLEEP_C2 3'h2
`define PPSC_SLEEP_C3 3'h3
`define PPSC_SLEEP_W 3

// core voltage select codes
`define PPSC_VSEL_W 5
`define PPSC_VSEL_NORMAL 5'h10
`define PPSC_VSEL_DEEP 5'h10
`define PPSC_VSEL_MIN 5'h02

// pll relock time after clock restart, ns, and cycles at 50 ns
`define PPSC_CLK_NS 50
`define PPSC_RELOCK_NS 2000
`define PPSC_RELOCK_CYC ((`PPSC_RELOCK_NS + `PPSC_CLK_NS - 1) / `PPSC_CLK_NS)

// reference clock activity: cycles without an edge before "stopped"
`define PPSC_REFIDLE_CYC 4

// number of interrupt lines
`define PPSC_IRQ_W 8

`endif

// File: src/ppsc_pkg.sv
`default_nettype none
`include "ppsc_consts.svh"
package ppsc_pkg;
	// processor power state, binary coded
	typedef enum logic [2:0] {
		PPSC_NORMAL = 3'h0,
		PPSC_HALT = 3'h1,
		PPSC_QUICK = 3'h2,
		PPSC_DEEP = 3'h3,
		PPSC_XDEEP = 3'h4,
		PPSC_RELOCK = 3'h5,
		PPSC_INIT = 3'h6
	} ppsc_state_e;
	typedef logic [`PPSC_SLEEP_W-1:0] ppsc_sleep_t;
endpackage
`default_nettype wire

// File: src/ppsc_link_if.sv
`default_nettype none
`include "ppsc_consts.svh"
// link between the southbridge end and the processor power controller
interface ppsc_link_if;
	logic stpclk_valid;
	logic [`PPSC_SLEEP_W-1:0] sleep_state_field;
	logic link_stop;
	logic input_ref_clock;
	logic core_low;
	logic [`PPSC_VSEL_W-1:0] core_voltage_select;
	logic sleeping;
	modport device (
		input stpclk_valid, sleep_state_field, link_stop,
		input input_ref_clock, core_low,
		output core_voltage_select, sleeping
	);
	modport host (
		output stpclk_valid, sleep_state_field, link_stop,
		output input_ref_clock, core_low,
		input core_voltage_select, sleeping
	);
endinterface
`default_nettype wire

// File: src/ppsc_device.sv
`default_nettype none
`include "ppsc_consts.svh"
module ppsc_device
	import ppsc_pkg::*;
#(
	parameter int IRQ_W = `PPSC_IRQ_W,
	parameter int RELOCK_CYC = `PPSC_RELOCK_CYC
) (
	input wire logic CLOCK,
	input wire logic RST,
	ppsc_link_if.device LINK,
	input wire logic HW_RESET,
	input wire logic HALT_EXEC,
	input wire logic WANT_LOW_V,
	input wire logic WAKE,
	input wire logic [IRQ_W-1:0] IRQ_IN,
	input wire logic SNOOP_REQ,
	output logic CORE_RUN,
	output logic SDRAM_SAVE,
	output logic SDRAM_SELF_REFRESH,
	output logic PLL_ON,
	output logic CTRL_RUN,
	output logic SNOOP_ACK,
	output logic [IRQ_W-1:0] IRQ_SERVE,
	output logic INIT_PULSE,
	output logic [2:0] STATE
);

	ppsc_state_e state_r, state_nxt;
	logic [IRQ_W-1:0] pend_r;
	logic [15:0] relock_cnt_r;
	logic [2:0] ref_hist_r;
	logic [3:0] idle_cnt_r;
	logic ref_alive;
	logic [`PPSC_VSEL_W-1:0] vsel_r;
	logic sleeping_r;
	logic stp_c2, stp_c3, awake;
	logic hw_rst_ok;

	// ----------------------------------------
	// reference clock activity
	// ----------------------------------------
	// history sampled: first flop read only by the second
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			ref_hist_r <= 3'h0;
		end else begin
			ref_hist_r <= {ref_hist_r[1:0], LINK.input_ref_clock};
		end
	end

	// count cycles since the last edge of the reference clock
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			idle_cnt_r <= 4'h0;
		end else if (ref_hist_r[2] != ref_hist_r[1]) begin
			idle_cnt_r <= 4'h0;
		end else if (idle_cnt_r != 4'(`PPSC_REFIDLE_CYC)) begin
			idle_cnt_r <= idle_cnt_r + 4'h1;
		end
	end
	assign ref_alive = (idle_cnt_r != 4'(`PPSC_REFIDLE_CYC));

	// ----------------------------------------
	// state transitions
	// ----------------------------------------
	assign stp_c2 = LINK.stpclk_valid &&
		LINK.sleep_state_field == `PPSC_SLEEP_C2;
	assign stp_c3 = LINK.stpclk_valid &&
		LINK.sleep_state_field == `PPSC_SLEEP_C3;
	assign awake = (state_r == PPSC_NORMAL) || (state_r == PPSC_HALT);
	// ignore reset, idle clock
	// a stalled reference cannot clock a clean init, so drop reset
	assign hw_rst_ok = HW_RESET && ref_alive;

	// next power state
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			PPSC_NORMAL: begin
				if (stp_c3)
					state_nxt = PPSC_DEEP;
				else if (stp_c2)
					state_nxt = PPSC_QUICK;
				else if (HALT_EXEC)
					state_nxt = PPSC_HALT;
			end
			PPSC_HALT: begin
				if (stp_c3)
					state_nxt = PPSC_DEEP;
				else if (stp_c2)
					state_nxt = PPSC_QUICK;
				else if (hw_rst_ok || (|IRQ_IN))
					state_nxt = PPSC_NORMAL;
			end
			PPSC_QUICK: begin
				if (hw_rst_ok)
					state_nxt = PPSC_INIT;
				else if (WAKE)
					state_nxt = PPSC_NORMAL;
			end
			PPSC_INIT: state_nxt = PPSC_NORMAL;
			PPSC_DEEP: begin
				if (LINK.core_low)
					state_nxt = PPSC_XDEEP;
				else if (WAKE && ref_alive)
					state_nxt = PPSC_RELOCK;
			end
			PPSC_XDEEP: begin
				if (!LINK.core_low && WAKE && ref_alive)
					state_nxt = PPSC_RELOCK;
			end
			PPSC_RELOCK: begin
				if (relock_cnt_r == 16'h0)
					state_nxt = PPSC_NORMAL;
			end
			default: state_nxt = PPSC_NORMAL;
		endcase
	end

	// state register; hw reset only counts while ref clock runs
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			state_r <= PPSC_NORMAL;
		end else begin
			state_r <= state_nxt;
		end
	end

	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			relock_cnt_r <= 16'h0;
		end else if (state_r != PPSC_RELOCK) begin
			relock_cnt_r <= 16'(RELOCK_CYC - 1);
		end else if (relock_cnt_r != 16'h0) begin
			relock_cnt_r <= relock_cnt_r - 16'h1;
		end
	end

	// ----------------------------------------
	// interrupts and snoops
	// ----------------------------------------
	// one pending bit per line, no count
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			pend_r <= '0;
		end else if (state_r == PPSC_QUICK) begin
			pend_r <= pend_r | IRQ_IN;
		end else if (state_r == PPSC_NORMAL) begin
			pend_r <= '0;
		end
	end

	// serve interrupts when running; latched ones on return to normal
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			IRQ_SERVE <= '0;
		end else if (state_r == PPSC_NORMAL) begin
			IRQ_SERVE <= IRQ_IN | pend_r;
		end else begin
			IRQ_SERVE <= '0;
		end
	end

	// snoops in awake and quick start only
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			SNOOP_ACK <= 1'b0;
		end else begin
			SNOOP_ACK <= SNOOP_REQ && (awake || state_r == PPSC_QUICK);
		end
	end

	// ----------------------------------------
	// power outputs
	// ----------------------------------------
	// registered from next state so outputs track state_r exactly
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			CORE_RUN <= 1'b1;
			SDRAM_SAVE <= 1'b0;
			SDRAM_SELF_REFRESH <= 1'b0;
			PLL_ON <= 1'b1;
			CTRL_RUN <= 1'b1;
			INIT_PULSE <= 1'b0;
			STATE <= 3'h0;
			sleeping_r <= 1'b0;
		end else begin
			CORE_RUN <= (state_nxt == PPSC_NORMAL);
			SDRAM_SAVE <= (state_nxt == PPSC_QUICK);
			SDRAM_SELF_REFRESH <= (state_nxt == PPSC_DEEP) ||
				(state_nxt == PPSC_XDEEP);
			PLL_ON <= !((state_nxt == PPSC_DEEP) ||
				(state_nxt == PPSC_XDEEP));
			CTRL_RUN <= (state_nxt != PPSC_DEEP) &&
				(state_nxt != PPSC_XDEEP) && (state_nxt != PPSC_RELOCK);
			INIT_PULSE <= (state_nxt == PPSC_INIT);
			STATE <= state_nxt;
			sleeping_r <= (state_nxt == PPSC_DEEP) ||
				(state_nxt == PPSC_XDEEP);
		end
	end

	// voltage select to regulator
	// minimum code only once the extended state holds, never before
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			vsel_r <= `PPSC_VSEL_NORMAL;
		end else if (state_r == PPSC_XDEEP && WANT_LOW_V) begin
			vsel_r <= `PPSC_VSEL_MIN;
		end else begin
			vsel_r <= `PPSC_VSEL_NORMAL;
		end
	end
	assign LINK.core_voltage_select = vsel_r;
	assign LINK.sleeping = sleeping_r;

endmodule
`default_nettype wire

// File: src/ppsc_host.sv
`default_nettype none
`include "ppsc_consts.svh"
module ppsc_host
	import ppsc_pkg::*;
(
	input wire logic CLOCK,
	input wire logic RST,
	ppsc_link_if.host LINK,
	input wire logic REQ_VALID,
	input wire logic [`PPSC_SLEEP_W-1:0] REQ_SLEEP,
	input wire logic REF_STOP,
	input wire logic CORE_LOW,
	output logic BUSY,
	output logic [`PPSC_VSEL_W-1:0] VSEL_SEEN
);

	logic stp_r;
	logic [`PPSC_SLEEP_W-1:0] field_r;
	logic ref_r;
	logic stop_r;
	logic low_r;

	// ----------------------------------------
	// stop-clock packet, one cycle per request
	// ----------------------------------------
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			stp_r <= 1'b0;
			field_r <= 3'h0;
		end else begin
			stp_r <= REQ_VALID;
			field_r <= REQ_VALID ? REQ_SLEEP : field_r;
		end
	end

	// reference clock divided by two, frozen while sleep wants it stopped
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			ref_r <= 1'b0;
		end else if (!(REF_STOP && LINK.sleeping)) begin
			ref_r <= !ref_r;
		end
	end

	// link stop held low in sleep
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			stop_r <= 1'b1;
			low_r <= 1'b0;
			BUSY <= 1'b0;
			VSEL_SEEN <= 5'h0;
		end else begin
			stop_r <= !LINK.sleeping;
			low_r <= CORE_LOW && LINK.sleeping;
			BUSY <= stp_r;
			VSEL_SEEN <= LINK.core_voltage_select;
		end
	end

	assign LINK.stpclk_valid = stp_r;
	assign LINK.sleep_state_field = field_r;
	assign LINK.input_ref_clock = ref_r;
	assign LINK.link_stop = stop_r;
	assign LINK.core_low = low_r;

endmodule
`default_nettype wire

// File: bench/ppsc_props.sv
`default_nettype none
`include "ppsc_consts.svh"
module ppsc_props (
	input wire logic CLOCK,
	input wire logic RST,
	input wire logic stpclk_valid,
	input wire logic [`PPSC_SLEEP_W-1:0] sleep_state_field,
	input wire logic link_stop,
	input wire logic core_low,
	input wire logic [`PPSC_VSEL_W-1:0] core_voltage_select,
	input wire logic sleeping
);
	default clocking @(posedge CLOCK); endclocking
	default disable iff (RST);
	// ----
	// link relations
	// ----
	a_deep_cause: assert property ($rose(sleeping) |->
		$past(stpclk_valid) && $past(sleep_state_field) == `PPSC_SLEEP_C3)
		else $error("sleeping rose without a deep packet");
	a_quick_awake: assert property (stpclk_valid &&
		sleep_state_field == `PPSC_SLEEP_C2 && !sleeping |=> !sleeping)
		else $error("quick request raised sleeping");
	a_low_entry: assert property (sleeping && $rose(core_low) |->
		##[1:2] core_voltage_select == `PPSC_VSEL_MIN)
		else $error("core voltage not lowered");
	a_low_cause: assert property (
		$rose(core_voltage_select == `PPSC_VSEL_MIN) |->
		$past(sleeping) && $past(core_low))
		else $error("core voltage lowered outside sleep");
	a_awake_volt: assert property ((!sleeping) [*3] |->
		core_voltage_select == `PPSC_VSEL_NORMAL)
		else $error("awake with wrong voltage code");
	a_reset_volt: assert property ($past(RST) |->
		core_voltage_select == `PPSC_VSEL_NORMAL)
		else $error("voltage code wrong after reset");
	a_stop_low: assert property (sleeping [*3] |-> !link_stop)
		else $error("link stop not low in sleep");
	a_field_legal: assert property (stpclk_valid |->
		sleep_state_field inside {`PPSC_SLEEP_C2, `PPSC_SLEEP_C3})
		else $error("packet with unknown sleep code");
endmodule
`default_nettype wire

// File: bench/tb_processor_power_state_control.sv
`default_nettype none
`include "ppsc_consts.svh"
`define CHK(a, b) chk((a) === (b), `__LINE__);
module tb_processor_power_state_control
	import ppsc_pkg::*;
();
	timeunit 1ns;
	timeprecision 1ns;
	logic CLOCK = 0, RST = 1, hw_rst = 0, halt = 0, low_v = 0, wake = 0;
	logic snp = 0, rv = 0, ref_stop = 0, core_low = 0, p;
	logic [`PPSC_IRQ_W-1:0] irq = 0, irq_srv;
	logic [2:0] rs = 0, st;
	logic core_run, sd_save, sd_sr, pll_on, ctrl_run, ack, init_p, busy;
	logic [`PPSC_VSEL_W-1:0] vseen;
	int n_fail = 0, tests_run = 0, k;
	ppsc_link_if lnk ();
	ppsc_device #(.RELOCK_CYC(4)) ppsc_device_i (.CLOCK(CLOCK), .RST(RST),
		.LINK(lnk), .HW_RESET(hw_rst), .HALT_EXEC(halt), .WANT_LOW_V(low_v),
		.WAKE(wake), .IRQ_IN(irq), .SNOOP_REQ(snp), .CORE_RUN(core_run),
		.SDRAM_SAVE(sd_save), .SDRAM_SELF_REFRESH(sd_sr), .PLL_ON(pll_on),
		.CTRL_RUN(ctrl_run), .SNOOP_ACK(ack), .IRQ_SERVE(irq_srv),
		.INIT_PULSE(init_p), .STATE(st));
	ppsc_host ppsc_host_i (.CLOCK(CLOCK), .RST(RST), .LINK(lnk),
		.REQ_VALID(rv), .REQ_SLEEP(rs), .REF_STOP(ref_stop),
		.CORE_LOW(core_low), .BUSY(busy), .VSEL_SEEN(vseen));
	ppsc_props ppsc_props_i (.CLOCK(CLOCK), .RST(RST),
		.stpclk_valid(lnk.stpclk_valid),
		.sleep_state_field(lnk.sleep_state_field),
		.link_stop(lnk.link_stop), .core_low(lnk.core_low),
		.core_voltage_select(lnk.core_voltage_select),
		.sleeping(lnk.sleeping));
	always #25 CLOCK = ~CLOCK;
	// ----
	// helpers
	// ----
	task stop_test();
		$display("checks %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task chk(input bit ok, input int ln);
		tests_run++;
		if (!ok) begin
			n_fail++;
			$display("MISMATCH %0t compare at line %0d", $time, ln);
		end
	endtask
	task go(input int n);
		repeat (n) @(negedge CLOCK);
	endtask
	// bounded wait; a state that never comes ends the run
	task wst(input ppsc_state_e s);
		for (int i = 0; i < 80 && st !== s; i++) go(1);
		tests_run++;
		if (st !== s) begin
			n_fail++;
			$display("MISMATCH %0t state wait", $time);
			stop_test();
		end
	endtask
	// idle cycle after the strobe so back-to-back calls never collide
	task pkt(input logic [2:0] code);
		rs = code;
		rv = 1;
		go(1);
		rv = 0;
		go(1);
		`CHK(busy, 1'b1)
	endtask
	// ----
	// tests
	// ----
	initial begin
		go(10);
		RST = 0;
		go(1);
		halt = 1;
		go(1);
		halt = 0;
		wst(PPSC_HALT);
		`CHK({core_run, ctrl_run}, 2'b01)
		snp = 1;
		go(1);
		`CHK(ack, 1'b1)
		snp = 0;
		irq = 8'h01;
		wst(PPSC_NORMAL);
		go(1);
		`CHK(irq_srv, 8'h01)
		irq = 0;
		go(2);
		$display("end halt");
		pkt(`PPSC_SLEEP_C2);
		wst(PPSC_QUICK);
		`CHK(sd_save, 1'b1)
		`CHK({core_run, ctrl_run}, 2'b01)
		snp = 1;
		irq = 8'h04;
		go(1);
		`CHK(ack, 1'b1)
		irq = 0;
		go(1);
		irq = 8'h04;
		go(1);
		irq = 0;
		snp = 0;
		`CHK(irq_srv, 8'h00)
		wake = 1;
		wst(PPSC_NORMAL);
		wake = 0;
		// two pulses latched, exactly one service expected
		p = 0;
		k = 0;
		repeat (8) begin
			if (irq_srv[2] === 1'b1 && !p) k++;
			p = irq_srv[2] === 1'b1;
			go(1);
		end
		`CHK(k, 1)
		pkt(`PPSC_SLEEP_C2);
		wst(PPSC_QUICK);
		hw_rst = 1;
		go(1);
		hw_rst = 0;
		wst(PPSC_INIT);
		`CHK(init_p, 1'b1)
		wst(PPSC_NORMAL);
		`CHK(init_p, 1'b0)
		$display("end quick");
		pkt(`PPSC_SLEEP_C3);
		wst(PPSC_DEEP);
		`CHK({pll_on, sd_sr, lnk.sleeping}, 3'b011)
		`CHK({core_run, ctrl_run}, 2'b00)
		snp = 1;
		irq = 8'h10;
		go(2);
		`CHK(ack, 1'b0)
		snp = 0;
		irq = 0;
		ref_stop = 1;
		core_low = 1;
		low_v = 1;
		wst(PPSC_XDEEP);
		go(2);
		`CHK(lnk.core_voltage_select, `PPSC_VSEL_MIN)
		`CHK(vseen, `PPSC_VSEL_MIN)
		hw_rst = 1;
		go(2);
		hw_rst = 0;
		`CHK(st, PPSC_XDEEP)
		core_low = 0;
		low_v = 0;
		ref_stop = 0;
		wake = 1;
		wst(PPSC_RELOCK);
		wake = 0;
		go(2);
		`CHK(st, PPSC_RELOCK)
		`CHK({pll_on, ctrl_run}, 2'b10)
		wst(PPSC_NORMAL);
		`CHK({core_run, ctrl_run, lnk.sleeping}, 3'b110)
		snp = 1;
		go(1);
		`CHK(ack, 1'b1)
		snp = 0;
		go(6);
		`CHK(irq_srv, 8'h00)
		$display("end deep");
		stop_test();
	end
endmodule
`default_nettype wire
